//--- include/rem_pkg.sv
/*
 Package for the relay event mask reporter: mask reset values, event codes,
 data item codes of channel 0 and the request command encoding.
 Assumes a bus front end that has already decoded the serial frames.
*/
package rem_pkg;
   // ************************************************************
   // Mask widths and reset values
   // ************************************************************
   localparam int MASK8_W = 8;
   localparam int RLY_W = 10;
   localparam logic [7:0] EARTH_UNB_MASK_RST = 8'h44; // Trip events only
   localparam logic [7:0] UC_EXT_MASK_RST = 8'h14; // Undercurrent trip, ext trip
   localparam logic [9:0] RELAY_MASK_RST = 10'h300; // Second trip output only
   // Field positions: start, start reset, trip, trip reset per stage
   localparam int EF_START_POS = 0;
   localparam int EF_START_RST_POS = 1;
   localparam int UB_START_POS = 4;
   localparam int UB_START_RST_POS = 5;
   localparam int UC_START_POS = 0;
   localparam int UC_START_RST_POS = 1;
   // ************************************************************
   // Event codes carried to the master
   // ************************************************************
   localparam logic [5:0] EV_BASE_EU = 6'h11; // Codes 17..24
   localparam logic [5:0] EV_BASE_UX = 6'h19; // Codes 25..32
   localparam logic [5:0] EV_BASE_RLY = 6'h21; // Codes 33..42
   localparam logic [5:0] EV_RESTART = 6'h32; // Code 50
   localparam logic [5:0] EV_OVERFLOW = 6'h33; // Code 51
   // ************************************************************
   // Data access on the serial bus
   // ************************************************************
   localparam logic [3:0] DATA_CHANNEL = 4'h0;
   localparam logic [7:0] ITEM_EU_MASK = 8'h9d; // Writable masks
   localparam logic [7:0] ITEM_UX_MASK = 8'h9e;
   localparam logic [7:0] ITEM_RLY_MASK = 8'h9f;
   localparam logic [7:0] ITEM_STARTUP = 8'ha0; // Read only status
   localparam int EV_DEPTH = 8;
   localparam int EV_AW = 3;
   typedef enum logic [1:0] {
      REM_CMD_NONE = 2'b00,
      REM_CMD_READ = 2'b01,
      REM_CMD_WRITE = 2'b10
   } rem_cmd_t;
   typedef enum logic [1:0] {
      REM_ANS_OK = 2'b00,
      REM_ANS_BAD_CHANNEL = 2'b01,
      REM_ANS_NOT_WRITABLE = 2'b10,
      REM_ANS_UNKNOWN = 2'b11
   } rem_status_t;
endpackage

//--- include/rem_evq_if.sv
/*
 Interface between the reporter and its event memory.
 Assumes one clock for both ends.
*/
`timescale 1ns/1ps
interface rem_evq_if;
   logic wr_en; // Write one event code
   logic [2:0] wr_addr;
   logic [5:0] wr_data;
   logic [2:0] rd_addr;
   logic [5:0] rd_data; // Registered read data
   modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr,
      input rd_data);
   modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr,
      output rd_data);
endinterface

//--- rtl/rem_evq_mem.sv
/*
 Small event code memory with registered read data.
 Assumes the controller keeps its own pointers and counts.
*/
`timescale 1ns/1ps
module rem_evq_mem (
   input wire logic clk,
   rem_evq_if.mem port
);
   import rem_pkg::*;
   logic [5:0] store [EV_DEPTH]; // Event code slots
   logic [5:0] rd_q;
   // ************************************************************
   // Storage and read register, no reset needed on the array
   // ************************************************************
   always_ff @(posedge clk) begin
      if (port.wr_en) begin
         store[port.wr_addr] <= port.wr_data;
      end
      rd_q <= store[port.rd_addr];
   end
   assign port.rd_data = rd_q;
endmodule // rem_evq_mem

//--- rtl/rem_event_sel.sv
/*
 Combinational mask and start-up filter for the masked event groups.
 Assumes one-cycle event pulses from the protection stages.
*/
`timescale 1ns/1ps
module rem_event_sel (
   input wire logic [7:0] eu_ev,
   input wire logic [7:0] ux_ev,
   input wire logic [9:0] rly_ev,
   input wire logic [7:0] eu_mask,
   input wire logic [7:0] ux_mask,
   input wire logic [9:0] rly_mask,
   input wire logic startup,
   output logic [25:0] sel
);
   import rem_pkg::*;
   logic [7:0] eu_keep; // Start events stripped during start-up
   logic [7:0] ux_keep;
   // ************************************************************
   // Filter
   // ************************************************************
   always_comb begin
      eu_keep = 8'hff;
      ux_keep = 8'hff;
      if (startup) begin // Trips still pass
         eu_keep[EF_START_POS] = 1'b0;
         eu_keep[EF_START_RST_POS] = 1'b0;
         eu_keep[UB_START_POS] = 1'b0;
         eu_keep[UB_START_RST_POS] = 1'b0;
         ux_keep[UC_START_POS] = 1'b0;
         ux_keep[UC_START_RST_POS] = 1'b0;
      end
      // A set mask bit reports, clear suppresses
      sel = {rly_ev & rly_mask, ux_ev & ux_mask & ux_keep, eu_ev & eu_mask & eu_keep};
   end
endmodule // rem_event_sel

//--- rtl/rem_reporter.sv
/*
 Relay event mask reporter: holds the three event masks, filters and
 queues events, and serves decoded read and write requests of the master.
 The output register ahead of the event memory holds one event more, so
 nine events can wait while the master stalls before any are dropped.
 Assumes a serial front end giving decoded requests, one per pulse, and
 one-cycle event pulses from the protection logic.
*/
`timescale 1ns/1ps
module rem_reporter (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] eu_event, // Earth-fault and unbalance pulses
   input wire logic [7:0] ux_event, // Undercurrent and external pulses
   input wire logic [9:0] relay_event, // Output relay pulses
   input wire logic startup_begin, // Motor start-up begins
   input wire logic startup_end, // Motor start-up ends
   input wire logic req_valid, // Decoded request pulse
   input wire rem_pkg::rem_cmd_t req_cmd,
   input wire logic [3:0] req_channel,
   input wire logic [7:0] req_item,
   input wire logic [9:0] req_wdata,
   input wire logic ev_pop, // Master took the offered event
   output logic resp_valid,
   output rem_pkg::rem_status_t resp_status,
   output logic [9:0] resp_data,
   output logic ev_valid,
   output logic [5:0] ev_code,
   output logic startup_active
);
   import rem_pkg::*;
   // ************************************************************
   // Declarations
   // ************************************************************
   logic [7:0] eu_mask, next_eu_mask; // Earth-fault/unbalance mask
   logic [7:0] ux_mask, next_ux_mask; // Undercurrent/external mask
   logic [9:0] rly_mask, next_rly_mask; // Output relay mask
   logic startup, next_startup; // Start-up condition
   // Registered answer to the master
   logic resp_v, next_resp_v;
   rem_status_t resp_s, next_resp_s;
   logic [9:0] resp_d, next_resp_d;
   // Event path
   logic [25:0] sel; // Masked, filtered events
   logic [25:0] pend, next_pend; // Events not yet queued
   logic restart_pend, next_restart_pend; // Restart event owed
   logic ovf_pend, next_ovf_pend; // Overflow event owed
   // Queue pointers and fill count; the count is one bit wider to show full
   logic [EV_AW-1:0] wptr, next_wptr;
   logic [EV_AW-1:0] rptr, next_rptr;
   logic [EV_AW:0] count, next_count;
   logic out_v, next_out_v; // Event offered to master
   logic [5:0] out_code, next_out_code;
   logic fetch, next_fetch; // Memory read in flight
   // Queue write side, decided each cycle
   logic push;
   logic [5:0] push_code;
   logic [25:0] take;
   // Queue read side
   logic pop_q;
   // Carrier to the event memory
   rem_evq_if evq ();

   // Lowest pending bit index, used for the event code
   // Scanning from the top lets the lowest set bit win last
   function automatic logic [4:0] first_set(input logic [25:0] v);
      logic [4:0] idx;
      idx = 5'h0;
      for (int i = 25; i >= 0; i--) begin
         if (v[i]) begin
            idx = 5'(i);
         end
      end
      return idx;
   endfunction

   // Code of a masked event by its bit index
   // Codes run on without gaps across the three groups
   function automatic logic [5:0] code_of(input logic [4:0] idx);
      logic [5:0] c;
      c = EV_BASE_EU + {1'b0, idx};
      return c;
   endfunction

   // Mask and start-up filter, purely combinational
   rem_event_sel u_sel (
      .eu_ev(eu_event),
      .ux_ev(ux_event),
      .rly_ev(relay_event),
      .eu_mask(eu_mask),
      .ux_mask(ux_mask),
      .rly_mask(rly_mask),
      .startup(startup),
      .sel(sel)
   );

   // Event memory; read data come out one cycle after the address
   rem_evq_mem u_mem (
      .clk(clk),
      .port(evq)
   );

   // ************************************************************
   // Start-up condition tracking
   // ************************************************************
   // Begin and end arrive as one-cycle pulses from the start-up logic
   // Begin wins a tie so that no start event slips through
   always_comb begin
      next_startup = startup;
      if (startup_begin) begin // Begin wins if both arrive
         next_startup = 1'b1;
      end else if (startup_end) begin
         next_startup = 1'b0;
      end
   end

   // ************************************************************
   // Request handling: masks and status over channel 0
   // ************************************************************
   // One answer per taken request, one cycle later
   // Status and data hold until the next answer for a slow reader
   // Refused requests change no mask
   always_comb begin
      next_eu_mask = eu_mask;
      next_ux_mask = ux_mask;
      next_rly_mask = rly_mask;
      next_resp_v = 1'b0;
      next_resp_s = resp_s;
      next_resp_d = resp_d;
      if (req_valid && req_cmd != REM_CMD_NONE) begin
         next_resp_v = 1'b1;
         next_resp_s = REM_ANS_OK;
         next_resp_d = 10'h000;
         // Channel check comes before any item decode
         if (req_channel != DATA_CHANNEL) begin // Only channel 0 holds data
            next_resp_s = REM_ANS_BAD_CHANNEL;
         end else if (req_cmd == REM_CMD_READ) begin
            unique case (req_item) // Read answer
               ITEM_EU_MASK: next_resp_d = {2'b00, eu_mask};
               ITEM_UX_MASK: next_resp_d = {2'b00, ux_mask};
               ITEM_RLY_MASK: next_resp_d = rly_mask;
               ITEM_STARTUP: next_resp_d = {9'h000, startup};
               default: next_resp_s = REM_ANS_UNKNOWN;
            endcase
         end else begin
            // Eight-bit masks keep the low byte of the value
            unique case (req_item)
               ITEM_EU_MASK: next_eu_mask = req_wdata[7:0];
               ITEM_UX_MASK: next_ux_mask = req_wdata[7:0];
               ITEM_RLY_MASK: next_rly_mask = req_wdata;
               ITEM_STARTUP: next_resp_s = REM_ANS_NOT_WRITABLE;
               default: next_resp_s = REM_ANS_UNKNOWN;
            endcase
         end
      end
   end

   // ************************************************************
   // Event collection and queue write
   // ************************************************************
   // Pending bits gather pulses until written, or until dropped at a full queue; a repeated pulse merges
   // At most one code is written per cycle, keeping the memory to one write port
   always_comb begin
      next_pend = pend | sel;
      next_restart_pend = restart_pend;
      next_ovf_pend = ovf_pend;
      next_wptr = wptr;
      push = 1'b0;
      push_code = 6'h00;
      take = 26'h0;
      // Restart first, then overflow, then masked events
      if (restart_pend) begin
         push_code = EV_RESTART;
      end else if (ovf_pend) begin
         push_code = EV_OVERFLOW;
      end else if (pend != 26'h0) begin
         push_code = code_of(first_set(pend));
         take[first_set(pend)] = 1'b1;
      end
      // Free space decides between writing and dropping
      if (restart_pend || ovf_pend || pend != 26'h0) begin
         if (count < (EV_AW+1)'(EV_DEPTH)) begin
            push = 1'b1;
            next_wptr = wptr + 1'b1;
            if (restart_pend) begin
               next_restart_pend = 1'b0;
            end else if (ovf_pend) begin
               next_ovf_pend = 1'b0;
            end
            next_pend = (pend & ~take) | sel; // New pulse wins over take
         end else if (pend != 26'h0) begin
            // Queue full: drop, remember one overflow
            next_pend = sel;
            next_ovf_pend = 1'b1;
         end
      end
   end

   // ************************************************************
   // Queue read: offer one event until the master pops it
   // ************************************************************
   // The memory read takes one cycle, so a fetch flag marks data in flight
   // A pop starts the next fetch in its own cycle; the offer drops for one
   always_comb begin
      next_rptr = rptr;
      next_out_v = out_v;
      next_out_code = out_code;
      next_fetch = 1'b0;
      pop_q = 1'b0;
      // The offer ends at the edge that sees the pop
      if (out_v && ev_pop) begin
         next_out_v = 1'b0;
      end
      if (fetch) begin // Registered read data now valid
         next_out_v = 1'b1;
         next_out_code = evq.rd_data;
      end else if ((!out_v || ev_pop) && count != '0 && !fetch) begin
         pop_q = 1'b1;
         next_fetch = 1'b1;
         next_rptr = rptr + 1'b1;
      end
      // Count moves by one at most each way
      next_count = count + (EV_AW+1)'(push) - (EV_AW+1)'(pop_q);
   end

   // Drive the controller side of the carrier
   assign evq.wr_en = push;
   assign evq.wr_addr = wptr;
   assign evq.wr_data = push_code;
   assign evq.rd_addr = rptr;

   // ************************************************************
   // State registers
   // ************************************************************
   // Masks return to their reset values and a restart event is owed
   // after every reset, so the master learns the masks were lost
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         // Every register here returns to a constant
         eu_mask <= EARTH_UNB_MASK_RST;
         ux_mask <= UC_EXT_MASK_RST;
         rly_mask <= RELAY_MASK_RST;
         startup <= 1'b0;
         resp_v <= 1'b0;
         resp_s <= REM_ANS_OK;
         resp_d <= 10'h000;
         pend <= 26'h0;
         restart_pend <= 1'b1; // Restart event after every reset
         ovf_pend <= 1'b0;
         wptr <= '0;
         rptr <= '0;
         count <= '0;
         out_v <= 1'b0;
         out_code <= 6'h00;
         fetch <= 1'b0;
      end else begin
         eu_mask <= next_eu_mask;
         ux_mask <= next_ux_mask;
         rly_mask <= next_rly_mask;
         startup <= next_startup;
         resp_v <= next_resp_v;
         resp_s <= next_resp_s;
         resp_d <= next_resp_d;
         pend <= next_pend;
         restart_pend <= next_restart_pend;
         ovf_pend <= next_ovf_pend;
         wptr <= next_wptr;
         rptr <= next_rptr;
         count <= next_count;
         out_v <= next_out_v;
         out_code <= next_out_code;
         fetch <= next_fetch;
      end
   end

   // Outputs straight from flip-flops
   // No logic between these registers and the pins
   assign resp_valid = resp_v;
   assign resp_status = resp_s;
   assign resp_data = resp_d;
   assign ev_valid = out_v;
   assign ev_code = out_code;
   assign startup_active = startup;
endmodule // rem_reporter

//--- dv/rem_reporter_asserts.sv
/*
 Port checker for the event mask reporter.
 Assumes it is bound to rem_reporter and sees only its ports.
*/
`timescale 1ns/1ps
module rem_reporter_asserts (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic startup_begin,
   input wire logic startup_end,
   input wire logic req_valid,
   input wire rem_pkg::rem_cmd_t req_cmd,
   input wire logic [3:0] req_channel,
   input wire logic [7:0] req_item,
   input wire logic ev_pop,
   input wire logic resp_valid,
   input wire rem_pkg::rem_status_t resp_status,
   input wire logic [9:0] resp_data,
   input wire logic ev_valid,
   input wire logic [5:0] ev_code,
   input wire logic startup_active
);
   import rem_pkg::*;
   // ****************************************
   // Request decode helpers
   // ****************************************
   logic req_on; // A request is taken
   logic ch_ok; // Data channel addressed
   logic item_ok; // Known item
   assign req_on = req_valid && (req_cmd != REM_CMD_NONE);
   assign ch_ok = (req_channel == DATA_CHANNEL);
   assign item_ok = (req_item >= ITEM_EU_MASK) && (req_item <= ITEM_STARTUP);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ****************************************
   // Properties
   // ****************************************
   a_resp_next: assert property (req_on |=> resp_valid)
      else $error("answer missing");
   a_resp_pulse: assert property (!req_on |=> !resp_valid)
      else $error("answer without request");
   a_bad_chan: assert property (req_on && !ch_ok |=>
      resp_status == REM_ANS_BAD_CHANNEL) else $error("channel not refused");
   a_ro_refused: assert property (req_on && ch_ok && req_cmd == REM_CMD_WRITE
      && req_item == ITEM_STARTUP |=> resp_status == REM_ANS_NOT_WRITABLE)
      else $error("read only item written");
   a_unknown_item: assert property (req_on && ch_ok && !item_ok |=>
      resp_status == REM_ANS_UNKNOWN) else $error("unknown item accepted");
   a_read_ok: assert property (req_on && ch_ok && item_ok && req_cmd == REM_CMD_READ
      |=> resp_status == REM_ANS_OK) else $error("read refused");
   a_mask_width: assert property (req_on && ch_ok && req_cmd == REM_CMD_READ &&
      (req_item == ITEM_EU_MASK || req_item == ITEM_UX_MASK) |=> resp_data[9:8] == 2'b00)
      else $error("eight bit mask too wide");
   a_startup_set: assert property (startup_begin |=> startup_active)
      else $error("start-up not entered");
   a_startup_clr: assert property (startup_end && !startup_begin |=> !startup_active)
      else $error("start-up not left");
   a_ev_stands: assert property (ev_valid && !ev_pop |=> ev_valid && $stable(ev_code))
      else $error("offered event lost");
   // Main scenarios
   c_bad_chan: cover property (req_on && !ch_ok);
   c_startup_ev: cover property (startup_active && ev_valid);
   c_overflow: cover property (ev_valid && ev_pop && ev_code == EV_OVERFLOW);
endmodule // rem_reporter_asserts
bind rem_reporter rem_reporter_asserts rem_reporter_asserts_i (.clk(clk), .rst_b(rst_b),
   .startup_begin(startup_begin), .startup_end(startup_end), .req_valid(req_valid),
   .req_cmd(req_cmd), .req_channel(req_channel), .req_item(req_item), .ev_pop(ev_pop),
   .resp_valid(resp_valid), .resp_status(resp_status), .resp_data(resp_data),
   .ev_valid(ev_valid), .ev_code(ev_code), .startup_active(startup_active));

//--- dv/rem_master_model.sv
/*
 Bus master model: takes offered events, can stall on request.
 Assumes the reporter offers one event at a time.
*/
`timescale 1ns/1ps
module rem_master_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ev_valid,
   input wire logic [5:0] ev_code,
   input wire logic hold, // Stall taking events
   output logic ev_pop,
   output logic got, // One pulse per event taken
   output logic [5:0] got_code
);
   // Link-status events would be born here; this bench needs none
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ev_pop <= 1'b0;
         got <= 1'b0;
         got_code <= 6'h00;
      end else begin
         got <= ev_pop && ev_valid;
         got_code <= ev_code;
         // One cycle pop, gap after it so a stale offer is never taken twice
         ev_pop <= ev_valid && !ev_pop && !hold;
      end
   end
endmodule // rem_master_model

//--- dv/relay_event_mask_reporter_bench.sv
/*
 Self-checking bench for the event mask reporter.
 Assumes the master model stands at the event side.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
   $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module relay_event_mask_reporter_bench;
   import rem_pkg::*;
   typedef struct {logic [7:0] it; logic [9:0] wd; logic [9:0] rd; int g; int b; int hit;} rem_row_t;
   logic clk = 1'b0, rst_b = 1'b0, startup_begin = 1'b0, startup_end = 1'b0;
   logic req_valid = 1'b0, hold = 1'b0, ev_pop, resp_valid, ev_valid, startup_active, got;
   logic [7:0] eu_event = 8'h00, ux_event = 8'h00, req_item = 8'h00;
   logic [9:0] relay_event = 10'h000, req_wdata = 10'h000, resp_data, rdat;
   logic [3:0] req_channel = 4'h0;
   logic [5:0] ev_code, got_code;
   rem_cmd_t req_cmd = REM_CMD_NONE;
   rem_status_t resp_status, rstat;
   int num_errors = 0, checked = 0;
   logic [5:0] rx[$]; // Codes taken by the master
   rem_row_t rows[7] = '{'{ITEM_EU_MASK, 10'h004, 10'h004, 0, 2, 1},
      '{ITEM_EU_MASK, 10'h3fb, 10'h0fb, 0, 2, 0}, '{ITEM_UX_MASK, 10'h080, 10'h080, 1, 7, 1},
      '{ITEM_UX_MASK, 10'h010, 10'h010, 1, 4, 1}, '{ITEM_RLY_MASK, 10'h200, 10'h200, 2, 9, 1},
      '{ITEM_RLY_MASK, 10'h1ff, 10'h1ff, 2, 9, 0}, '{ITEM_RLY_MASK, 10'h001, 10'h001, 2, 0, 1}};
   always #20 clk = ~clk;
   rem_reporter rem_reporter_i (.clk(clk), .rst_b(rst_b), .eu_event(eu_event),
      .ux_event(ux_event), .relay_event(relay_event), .startup_begin(startup_begin),
      .startup_end(startup_end), .req_valid(req_valid), .req_cmd(req_cmd),
      .req_channel(req_channel), .req_item(req_item), .req_wdata(req_wdata), .ev_pop(ev_pop),
      .resp_valid(resp_valid), .resp_status(resp_status), .resp_data(resp_data),
      .ev_valid(ev_valid), .ev_code(ev_code), .startup_active(startup_active));
   rem_master_model rem_master_model_i (.clk(clk), .rst_b(rst_b), .ev_valid(ev_valid),
      .ev_code(ev_code), .hold(hold), .ev_pop(ev_pop), .got(got), .got_code(got_code));
   // Log every event the master takes
   always @(posedge clk) if (got === 1'b1) rx.push_back(got_code);
   // ****************************************
   // Tasks
   // ****************************************
   task automatic wrap_up();
      $display("Errors %0d in %0d checks", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   function automatic logic [5:0] code(int g, int b);
      return 6'((g == 0 ? EV_BASE_EU : g == 1 ? EV_BASE_UX : EV_BASE_RLY) + b);
   endfunction
   // One request, answer sampled in the cycle after it is taken
   task automatic req(rem_cmd_t c, logic [3:0] ch, logic [7:0] it, logic [9:0] wd);
      @(posedge clk);
      req_valid <= 1'b1;
      req_cmd <= c;
      req_channel <= ch;
      req_item <= it;
      req_wdata <= wd;
      @(posedge clk);
      req_valid <= 1'b0;
      req_cmd <= REM_CMD_NONE;
      #1;
      `CHK(resp_valid, 1'b1)
      rstat = resp_status;
      rdat = resp_data;
   endtask
   task automatic fire(int g, int b);
      @(posedge clk);
      if (g == 0) eu_event <= 8'h01 << b;
      else if (g == 1) ux_event <= 8'h01 << b;
      else relay_event <= 10'h001 << b;
      @(posedge clk);
      {eu_event, ux_event, relay_event} <= '0;
   endtask
   task automatic sp(logic b); // Start-up begin or end pulse
      @(posedge clk);
      if (b) startup_begin <= 1'b1;
      else startup_end <= 1'b1;
      @(posedge clk);
      {startup_begin, startup_end} <= 2'b00;
      #1;
      `CHK(startup_active, b)
   endtask
   // Bounded wait for n events, then a short settle for strays
   task automatic wait_rx(int n);
      int k;
      k = 0;
      while (rx.size() < n && k < 80) begin
         @(posedge clk);
         k++;
      end
      repeat (n == 0 ? 30 : 6) @(posedge clk);
      if (rx.size() < n) begin
         num_errors++;
         $display("MISMATCH %0t event wait ran out", $time);
         wrap_up();
      end
   endtask
   task automatic reset_chk();
      rst_b <= 1'b0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      rx.delete();
      wait_rx(1);
      `CHK(rx[0], EV_RESTART)
      rx.delete();
      req(REM_CMD_READ, 4'h0, ITEM_EU_MASK, 10'h000);
      `CHK(rdat, 10'h044)
      req(REM_CMD_READ, 4'h0, ITEM_UX_MASK, 10'h000);
      `CHK(rdat, 10'h014)
      req(REM_CMD_READ, 4'h0, ITEM_RLY_MASK, 10'h000);
      `CHK(rdat, 10'h300)
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      reset_chk();
      foreach (rows[i]) begin
         req(REM_CMD_WRITE, 4'h0, rows[i].it, rows[i].wd);
         `CHK(rstat, REM_ANS_OK)
         req(REM_CMD_READ, 4'h0, rows[i].it, 10'h000);
         `CHK(rdat, rows[i].rd)
         fire(rows[i].g, rows[i].b);
         wait_rx(rows[i].hit);
         `CHK(rx.size(), rows[i].hit)
         if (rows[i].hit == 1) `CHK(rx[0], code(rows[i].g, rows[i].b))
         rx.delete();
      end
      // Start events withheld in start-up, trips pass
      req(REM_CMD_WRITE, 4'h0, ITEM_EU_MASK, 10'h0ff);
      sp(1'b1);
      req(REM_CMD_READ, 4'h0, ITEM_STARTUP, 10'h000);
      `CHK(rdat, 10'h001)
      fire(0, 0);
      fire(0, 5);
      fire(0, 6);
      wait_rx(1);
      `CHK(rx.size(), 1)
      `CHK(rx[0], code(0, 6))
      rx.delete();
      sp(1'b0);
      fire(0, 0);
      wait_rx(1);
      `CHK(rx[0], code(0, 0))
      rx.delete();
      // Refusals leave the masks alone
      req(REM_CMD_READ, 4'h1, ITEM_EU_MASK, 10'h000);
      `CHK(rstat, REM_ANS_BAD_CHANNEL)
      req(REM_CMD_WRITE, 4'h1, ITEM_EU_MASK, 10'h000);
      `CHK(rstat, REM_ANS_BAD_CHANNEL)
      req(REM_CMD_WRITE, 4'h0, ITEM_STARTUP, 10'h001);
      `CHK(rstat, REM_ANS_NOT_WRITABLE)
      req(REM_CMD_READ, 4'h0, 8'h55, 10'h000);
      `CHK(rstat, REM_ANS_UNKNOWN)
      req(REM_CMD_READ, 4'h0, ITEM_EU_MASK, 10'h000);
      `CHK(rdat, 10'h0ff)
      // Master stalls while twelve events arrive: the offer and eight slots keep nine
      req(REM_CMD_WRITE, 4'h0, ITEM_UX_MASK, 10'h0ff);
      hold <= 1'b1;
      for (int i = 0; i < 8; i++) fire(0, i);
      for (int i = 0; i < 4; i++) fire(1, i);
      repeat (5) @(posedge clk);
      hold <= 1'b0;
      wait_rx(10);
      for (int i = 0; i < 8; i++) `CHK(rx[i], code(0, i))
      `CHK(rx[8], code(1, 0))
      `CHK(rx[9], EV_OVERFLOW)
      `CHK(rx.size(), 10)
      reset_chk();
      wrap_up();
   end
endmodule // relay_event_mask_reporter_bench
